// File: pll_cfg_pkg.sv
// constants for the pll configuration and status logic
// assumes a 20 MHz system clock and one pll instance
package pll_cfg_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  // loss-of-signal validation times
  localparam int unsigned VAL_LONG_S   = 13;
  localparam int unsigned VAL_SHORT_MS = 100;
  localparam longint unsigned VAL_LONG_CYC  = longint'(VAL_LONG_S) * CLK_HZ;
  localparam longint unsigned VAL_SHORT_CYC = longint'(VAL_SHORT_MS) * (CLK_HZ / 1000);

  // loop bandwidth in hertz
  localparam logic [1:0] BW_SEL_3200 = 2'h0;
  localparam logic [1:0] BW_SEL_1600 = 2'h1;
  localparam logic [1:0] BW_SEL_800  = 2'h2;
  localparam logic [1:0] BW_SEL_6400 = 2'h3;
  localparam logic [13:0] BW_HZ_3200 = 14'hC80;
  localparam logic [13:0] BW_HZ_1600 = 14'h640;
  localparam logic [13:0] BW_HZ_800  = 14'h320;
  localparam logic [13:0] BW_HZ_6400 = 14'h1900;

  // fec ratio codes
  localparam logic [1:0] FEC_NONE = 2'h0;
  localparam logic [1:0] FEC_OUT  = 2'h1;
  localparam logic [1:0] FEC_IN   = 2'h2;
  localparam logic [1:0] FEC_RSVD = 2'h3;
  localparam logic [7:0] FEC_255  = 8'hFF;
  localparam logic [7:0] FEC_238  = 8'hEE;
  localparam logic [7:0] FEC_ONE  = 8'h01;

  // calibration and lock lengths in cycles
  localparam int unsigned CAL_CYC  = 64;
  localparam int unsigned LOCK_CYC = 256;

  // apb register map
  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ    = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00C;

  // interrupt bits
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_CAL_DONE = 0;
  localparam int unsigned IRQ_LOS_SET  = 1;
  localparam int unsigned IRQ_LOS_CLR  = 2;

endpackage

// File: pin_sync.sv
// two flip-flop synchroniser for a bus of pin inputs
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb begin
    s1_nxt = srst ? '0 : din;
    s2_nxt = srst ? '0 : s1_r;
  end

  always_ff @(posedge clk) begin
    s1_r <= s1_nxt;
    dout <= s2_nxt;
  end
endmodule
`default_nettype wire

// File: los_validator.sv
// loss-of-signal alarm with a validation interval before clearing
// assumes clk_ok is already synchronised
`timescale 1ns/1ps
`default_nettype none
module los_validator #(
  parameter longint unsigned LONG_CYC  = pll_cfg_pkg::VAL_LONG_CYC,
  parameter longint unsigned SHORT_CYC = pll_cfg_pkg::VAL_SHORT_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_ok,
  input  wire logic long_sel,
  output logic      los
);
  logic [28:0] cnt_r;
  logic [28:0] cnt_nxt;
  logic        los_nxt;
  logic [28:0] limit;

  always_comb begin
    limit   = long_sel ? 29'(LONG_CYC) : 29'(SHORT_CYC);
    cnt_nxt = cnt_r;
    los_nxt = los;
    if (srst) begin
      cnt_nxt = '0;
      los_nxt = 1'b1;
    end else if (!clk_ok) begin
      cnt_nxt = '0;
      los_nxt = 1'b1;
    end else if (los) begin
      if (cnt_r >= limit - 29'h1) begin
        los_nxt = 1'b0;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 29'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    cnt_r <= cnt_nxt;
    los   <= los_nxt;
  end

  los_hold_a: assert property (@(posedge clk) disable iff (srst)
    !clk_ok |=> los) else $error("alarm dropped while clock invalid");
  los_short_a: assert property (@(posedge clk) disable iff (srst)
    $fell(los) |-> cnt_r == '0 && $past(clk_ok) && $past(cnt_r) >= $past(limit) - 29'h1)
    else $error("alarm cleared without valid clock");
endmodule
`default_nettype wire

// File: pll_config_status_logic.sv
// pin configuration decode, calibration status and los alarm of the pll
// assumes pins are asynchronous, apb master on clk
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pll_config_status_logic #(
  parameter longint unsigned LONG_CYC  = pll_cfg_pkg::VAL_LONG_CYC,
  parameter longint unsigned SHORT_CYC = pll_cfg_pkg::VAL_SHORT_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        reset_calibrate_n,
  input  wire logic [1:0]  loop_bw_select,
  input  wire logic        bw_doubler,
  input  wire logic        fixed_delay_select,
  input  wire logic [1:0]  fec_ratio_select,
  input  wire logic        los_validation_select,
  input  wire logic        input_clk_valid,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             cal_in_progress,
  output logic             los_alarm,
  output logic [14:0]      loop_bw_hz,
  output logic [7:0]       fec_num,
  output logic [7:0]       fec_den,
  output logic             cfg_error,
  output logic             irq
);

  typedef enum logic [1:0] {ST_RESET, ST_CAL, ST_LOCK, ST_RUN} cal_state_e;

  localparam int IRQ_W_L = pll_cfg_pkg::IRQ_W;

  cal_state_e state_r;
  cal_state_e state_nxt;
  logic [8:0] seq_cnt_r;
  logic [8:0] seq_cnt_nxt;
  logic       rstn_d_r;
  logic       rstn_d_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [8:0] pins_s;
  // undriven pins default low via pulldown
  pin_sync #(.W(9)) u_sync (
    .clk  (clk),
    .srst (srst),
    .din  ({reset_calibrate_n, loop_bw_select, bw_doubler, fixed_delay_select,
            fec_ratio_select, los_validation_select, input_clk_valid}),
    .dout (pins_s)
  );

  logic       rstn_s;
  logic [1:0] bw_s;
  logic       dbl_s;
  logic       fxd_s;
  logic [1:0] fec_s;
  logic       val_s;
  logic       ck_ok_s;
  assign rstn_s  = pins_s[8];
  assign bw_s    = pins_s[7:6];
  assign dbl_s   = pins_s[5];
  assign fxd_s   = pins_s[4];
  assign fec_s   = pins_s[3:2];
  assign val_s   = pins_s[1];
  assign ck_ok_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // los alarm

  logic los_w;
  los_validator #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_los (
    .clk      (clk),
    .srst     (srst || !rstn_s),
    .clk_ok   (ck_ok_s && state_r == ST_RUN),
    .long_sel (val_s),
    .los      (los_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequence

  always_comb begin
    state_nxt   = state_r;
    seq_cnt_nxt = seq_cnt_r + 9'h1;
    rstn_d_nxt  = rstn_s;
    if (srst || !rstn_s) begin
      state_nxt   = ST_RESET;
      seq_cnt_nxt = '0;
      rstn_d_nxt  = srst ? 1'b0 : rstn_s;
    end else begin
      case (state_r)
        ST_RESET: begin
          seq_cnt_nxt = '0;
          if (!rstn_d_r) begin
            state_nxt = ST_CAL;
          end
        end
        ST_CAL: begin
          if (seq_cnt_r == 9'(pll_cfg_pkg::CAL_CYC - 1)) begin
            state_nxt   = ST_LOCK;
            seq_cnt_nxt = '0;
          end
        end
        ST_LOCK: begin
          if (seq_cnt_r == 9'(pll_cfg_pkg::LOCK_CYC - 1)) begin
            state_nxt   = ST_RUN;
            seq_cnt_nxt = '0;
          end
        end
        ST_RUN: begin
          seq_cnt_nxt = '0;
        end
        default: begin
          state_nxt = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_r   <= state_nxt;
    seq_cnt_r <= seq_cnt_nxt;
    rstn_d_r  <= rstn_d_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode and outputs

  logic [14:0]          bw_nxt;
  logic [7:0]           num_nxt;
  logic [7:0]           den_nxt;
  logic                 cal_nxt;
  logic                 err_nxt;
  logic [13:0]          bw_base;
  logic [IRQ_W_L-1:0]   irq_st_r;
  logic [IRQ_W_L-1:0]   irq_st_nxt;
  logic [IRQ_W_L-1:0]   irq_mask_r;
  logic [IRQ_W_L-1:0]   irq_mask_nxt;
  logic                 los_d_r;
  logic                 irq_nxt;

  always_comb begin
    case (bw_s)
      pll_cfg_pkg::BW_SEL_3200: bw_base = pll_cfg_pkg::BW_HZ_3200;
      pll_cfg_pkg::BW_SEL_1600: bw_base = pll_cfg_pkg::BW_HZ_1600;
      pll_cfg_pkg::BW_SEL_800:  bw_base = pll_cfg_pkg::BW_HZ_800;
      default:                  bw_base = pll_cfg_pkg::BW_HZ_6400;
    endcase
    bw_nxt = dbl_s ? {bw_base, 1'b0} : {1'b0, bw_base};
    case (fec_s)
      pll_cfg_pkg::FEC_OUT: begin
        num_nxt = pll_cfg_pkg::FEC_255;
        den_nxt = pll_cfg_pkg::FEC_238;
      end
      pll_cfg_pkg::FEC_IN: begin
        num_nxt = pll_cfg_pkg::FEC_238;
        den_nxt = pll_cfg_pkg::FEC_255;
      end
      default: begin
        num_nxt = pll_cfg_pkg::FEC_ONE;
        den_nxt = pll_cfg_pkg::FEC_ONE;
      end
    endcase
    err_nxt = (dbl_s && (!fxd_s || fec_s != pll_cfg_pkg::FEC_NONE))
              || fec_s == pll_cfg_pkg::FEC_RSVD;
    // calibration flag during cal and lock
    cal_nxt = state_nxt == ST_CAL || state_nxt == ST_LOCK;
    if (srst) begin
      bw_nxt  = '0;
      num_nxt = pll_cfg_pkg::FEC_ONE;
      den_nxt = pll_cfg_pkg::FEC_ONE;
      err_nxt = 1'b0;
      cal_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and interrupts

  logic        wr_en;
  logic [31:0] rd_nxt;
  logic        err_rd;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    irq_st_nxt = irq_st_r;
    irq_mask_nxt = irq_mask_r;
    rd_nxt = '0;
    err_rd = 1'b0;
    case (paddr)
      pll_cfg_pkg::ADDR_CFG:
        rd_nxt = {15'h0, loop_bw_hz, fec_s};
      pll_cfg_pkg::ADDR_STATUS:
        rd_nxt = {28'h0, state_r, los_alarm, cal_in_progress};
      pll_cfg_pkg::ADDR_IRQ:  rd_nxt = {29'h0, irq_st_r};
      pll_cfg_pkg::ADDR_MASK: rd_nxt = {29'h0, irq_mask_r};
      default: err_rd = 1'b1;
    endcase
    if (wr_en && paddr == pll_cfg_pkg::ADDR_IRQ) begin
      irq_st_nxt = irq_st_r & ~pwdata[IRQ_W_L-1:0];
    end
    if (wr_en && paddr == pll_cfg_pkg::ADDR_MASK) begin
      irq_mask_nxt = pwdata[IRQ_W_L-1:0];
    end
    // events set after clear so set wins
    if (cal_in_progress && !cal_nxt) begin
      irq_st_nxt[pll_cfg_pkg::IRQ_CAL_DONE] = 1'b1;
    end
    if (los_w && !los_d_r) begin
      irq_st_nxt[pll_cfg_pkg::IRQ_LOS_SET] = 1'b1;
    end
    if (!los_w && los_d_r) begin
      irq_st_nxt[pll_cfg_pkg::IRQ_LOS_CLR] = 1'b1;
    end
    if (srst) begin
      irq_st_nxt   = '0;
      irq_mask_nxt = '0;
    end
    irq_nxt = |(irq_st_nxt & irq_mask_nxt);
  end

  always_ff @(posedge clk) begin
    loop_bw_hz      <= bw_nxt;
    fec_num         <= num_nxt;
    fec_den         <= den_nxt;
    cfg_error       <= err_nxt;
    cal_in_progress <= cal_nxt;
    los_alarm       <= srst ? 1'b1 : los_w;
    los_d_r         <= srst ? 1'b1 : los_w;
    irq_st_r        <= irq_st_nxt;
    irq_mask_r      <= irq_mask_nxt;
    irq             <= srst ? 1'b0 : irq_nxt;
    pready          <= srst ? 1'b0 : (psel && !penable);
    pslverr         <= srst ? 1'b0 : (psel && !penable && err_rd);
    prdata          <= (srst || !(psel && !penable)) ? 32'h0 : rd_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  cal_flag_a: assert property (@(posedge clk) disable iff (srst)
    cal_in_progress == (state_r == ST_CAL || state_r == ST_LOCK))
    else $error("calibration flag out of step");
  rst_start_a: assert property (@(posedge clk) disable iff (srst)
    state_r == ST_RESET && !rstn_d_r && rstn_s |=> state_r == ST_CAL)
    else $error("calibration not started on reset release");
  bw_double_a: assert property (@(posedge clk) disable iff (srst)
    $past(dbl_s) && $past(bw_s) == pll_cfg_pkg::BW_SEL_800 |-> loop_bw_hz == 15'h640)
    else $error("doubled bandwidth wrong");
  bw_base_a: assert property (@(posedge clk) disable iff (srst)
    !$past(dbl_s) && $past(bw_s) == pll_cfg_pkg::BW_SEL_6400 |-> loop_bw_hz == 15'h1900)
    else $error("base bandwidth wrong");
  fec_out_a: assert property (@(posedge clk) disable iff (srst)
    $past(fec_s) == pll_cfg_pkg::FEC_OUT |-> fec_num == 8'hFF && fec_den == 8'hEE)
    else $error("fec scaling wrong");
  cfg_err_a: assert property (@(posedge clk) disable iff (srst)
    $past(dbl_s) && !$past(fxd_s) |-> cfg_error)
    else $error("doubler misuse not flagged");
  los_keep_a: assert property (@(posedge clk) disable iff (srst)
    !ck_ok_s ##1 1'b1 |=> los_alarm) else $error("alarm dropped during loss");
  los_long_a: assert property (@(posedge clk) disable iff (srst)
    $rose(los_alarm) |-> los_alarm [*8]) else $error("alarm cleared too soon");

  cal_run_c: cover property (@(posedge clk) $fell(cal_in_progress));
  los_clr_c: cover property (@(posedge clk) $fell(los_alarm));
  irq_c:     cover property (@(posedge clk) $rose(irq));
endmodule
`default_nettype wire

// File: board_strap.sv
// board controller model driving the pll configuration pins
// assumes the bench requests settings at the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module board_strap (
  input  wire logic       clk,
  input  wire logic [1:0] want_bw,
  input  wire logic       want_dbl,
  input  wire logic [1:0] want_fec,
  input  wire logic       want_val,
  input  wire logic       floating,
  input  wire logic       break_rule,
  output var  logic [1:0] loop_bw_select,
  output var  logic       bw_doubler,
  output var  logic       fixed_delay_select,
  output var  logic [1:0] fec_ratio_select,
  output var  logic       los_validation_select
);
  always_ff @(posedge clk) begin
    if (floating) begin
      loop_bw_select        <= 2'h0;
      bw_doubler            <= 1'b0;
      fixed_delay_select    <= 1'b0;
      fec_ratio_select      <= 2'h0;
      los_validation_select <= 1'b0;
    end else begin
      loop_bw_select        <= want_bw;
      bw_doubler            <= want_dbl;
      los_validation_select <= want_val;
      // doubler forces delay high, fec zero, unless break_rule
      fixed_delay_select    <= want_dbl & ~break_rule;
      fec_ratio_select      <= (want_dbl & ~break_rule) ? 2'h0 : want_fec;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the pll configuration and status logic
// assumes short validation counts of 20 and 50 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, srst = 1, rstn = 0, valid = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cal, los, cfg_err, irq, er;
  logic [14:0] bw_hz;
  logic [7:0]  fnum, fden;
  logic [1:0]  w_bw = 2'h0, w_fec = 2'h0, bsel, fsel;
  logic        w_dbl = 0, w_val = 0, flt = 1, brk = 0, dbl, fxd, vsel;
  logic [14:0] hz [4] = '{15'h0C80, 15'h0640, 15'h0320, 15'h1900};
  int          error_cnt = 0, check_count = 0, n;

  always #25 clk = ~clk;

  board_strap board_strap_i (.clk(clk), .want_bw(w_bw), .want_dbl(w_dbl), .want_fec(w_fec),
    .want_val(w_val), .floating(flt), .break_rule(brk), .loop_bw_select(bsel),
    .bw_doubler(dbl), .fixed_delay_select(fxd), .fec_ratio_select(fsel),
    .los_validation_select(vsel));

  pll_config_status_logic #(.LONG_CYC(50), .SHORT_CYC(20)) pll_config_status_logic_i (
    .clk(clk), .srst(srst), .reset_calibrate_n(rstn), .loop_bw_select(bsel),
    .bw_doubler(dbl), .fixed_delay_select(fxd), .fec_ratio_select(fsel),
    .los_validation_select(vsel), .input_clk_valid(valid), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .cal_in_progress(cal), .los_alarm(los), .loop_bw_hz(bw_hz),
    .fec_num(fnum), .fec_den(fden), .cfg_error(cfg_err), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pins(input logic [1:0] b, input logic d, input logic [1:0] f, input logic v,
                      input logic fl, input logic bk);
    w_bw  <= b;
    w_dbl <= d;
    w_fec <= f;
    w_val <= v;
    flt   <= fl;
    brk   <= bk;
    cyc(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cal;
    chk("los_at_reset", 1, los);
    rstn <= 1'b1;
    n = 0;
    while (cal !== 1'b1 && n < 20) begin
      n++;
      cyc(1);
    end
    n = 0;
    while (cal === 1'b1 && n < 1000) begin
      n++;
      cyc(1);
    end
    chk("cal_len", pll_cfg_pkg::CAL_CYC + pll_cfg_pkg::LOCK_CYC, n);
    apb(1'b0, pll_cfg_pkg::ADDR_IRQ, 32'h0);
    chk("cal_done_irq", 1, rd[pll_cfg_pkg::IRQ_CAL_DONE]);
    apb(1'b0, pll_cfg_pkg::ADDR_STATUS, 32'h0);
    chk("status_flags", 32'h2, rd & 32'h3);
    apb(1'b1, pll_cfg_pkg::ADDR_MASK, 32'h1);
    cyc(3);
    chk("irq_on", 1, irq);
    apb(1'b1, pll_cfg_pkg::ADDR_IRQ, 32'h1);
    cyc(3);
    chk("irq_off", 0, irq);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
  endtask

  task automatic t_bw;
    for (int b = 0; b < 8; b++) begin
      pins(b[1:0], b[2], 2'h0, 1'b0, 1'b0, 1'b0);
      chk("bw_hz", 32'(hz[b[1:0]]) << b[2], bw_hz);
      chk("cfg_ok", 0, cfg_err);
    end
    pins(2'h1, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
    chk("dbl_bad", 1, cfg_err);
    apb(1'b0, pll_cfg_pkg::ADDR_CFG, 32'h0);
    chk("cfg_reg", 32'h3202, rd);
  endtask

  task automatic t_fec;
    pins(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    chk("fec0", 32'h0101, {fnum, fden});
    pins(2'h0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0);
    chk("fec1", 32'hFFEE, {fnum, fden});
    pins(2'h0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
    chk("fec2", 32'hEEFF, {fnum, fden});
    pins(2'h0, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
    chk("fec3", 1, cfg_err);
    pins(2'h3, 1'b1, 2'h3, 1'b1, 1'b1, 1'b0);
    chk("float_bw", 32'h0C80, bw_hz);
    chk("float_fec", 32'h0101, {fnum, fden});
  endtask

  task automatic t_los(input logic v, input int lim);
    pins(2'h0, 1'b0, 2'h0, v, 1'b0, 1'b0);
    valid <= 1'b1;
    cyc(lim - 5);
    valid <= 1'b0;
    cyc(4);
    chk("los_restart", 1, los);
    valid <= 1'b1;
    n = 0;
    while (los === 1'b1 && n < 200) begin
      n++;
      cyc(1);
    end
    chk("los_time", 1, n >= lim && n <= lim + 6);
    apb(1'b0, pll_cfg_pkg::ADDR_IRQ, 32'h0);
    chk("los_clr_irq", 1, rd[pll_cfg_pkg::IRQ_LOS_CLR]);
    apb(1'b1, pll_cfg_pkg::ADDR_IRQ, 32'h7);
    valid <= 1'b0;
    cyc(6);
    chk("los_again", 1, los);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    cyc(20);
    srst <= 1'b0;
    cyc(2);
    t_cal;
    t_bw;
    t_fec;
    t_los(1'b0, 20);
    t_los(1'b1, 50);
    wrap_up;
  end

  initial begin
    cyc(20000);
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
